// ==== verilog/tarte_pkg.sv ====
package tarte_pkg;
  localparam int TARTE_NIB_W = 4;
  localparam int TARTE_BYTE_W = 8;
  localparam int TARTE_DREG_W = 3;
  localparam int TARTE_PAGE_W = 6;
  localparam int TARTE_LOW_W = 7;
  localparam int TARTE_PC_W = 13;
  localparam int TARTE_SP_W = 3;
  localparam logic [5:0] TARTE_PAGE_MAX = 6'h3F;
  localparam logic [3:0] TARTE_ACC_RST = 4'h0;
  localparam logic [3:0] TARTE_B_RST = 4'h0;
  localparam logic [2:0] TARTE_SP_RST = 3'h7;
  localparam logic [12:0] TARTE_PC_RST = 13'h0000;
  localparam logic [1:0] TARTE_OP_ROM = 2'h0;
  localparam logic [1:0] TARTE_OP_PRESC = 2'h1;
  localparam logic [1:0] TARTE_OP_SIO = 2'h2;
  localparam logic [1:0] TARTE_OP_DREG = 2'h3;
  localparam logic TARTE_ACC_TOP_CLEAR = 1'b0;
  typedef enum logic [3:0] {
    TARTE_IDLE = 4'b0001,
    TARTE_CALL = 4'b0010,
    TARTE_FETCH = 4'b0100,
    TARTE_RET = 4'b1000
  } tarte_state_type;
endpackage : tarte_pkg

// ==== verilog/tarte_split.sv ====
`timescale 1ns/1ps
// Splits a byte into the upper nibble for B and the lower nibble for A
module tarte_split (
  input wire logic [7:0] byte_i,
  output logic [3:0] hi_o,
  output logic [3:0] lo_o
);
  assign hi_o = byte_i[tarte_pkg::TARTE_BYTE_W-1:tarte_pkg::TARTE_NIB_W];
  assign lo_o = byte_i[tarte_pkg::TARTE_NIB_W-1:0];
endmodule : tarte_split

// ==== verilog/tarte_exec.sv ====
`timescale 1ns/1ps
// How it works
// - The ROM table read bumps the stack pointer, pushes the program counter, then loads the page part with the operand and the low part with D bits then A bits.
// - The ROM table read puts word bits 7-4 into B and 3-0 into A, then pops the program counter and drops the stack pointer.
// - The page operand takes any value 0 to 63.
// - The prescaler read copies its upper nibble to B and lower nibble to A in one cycle.
// - The serial shift read copies bits 7-4 to B and bits 3-0 to A.
// - The D read copies the three D bits into A bits 2-0.
// - The D read always writes zero into A bit 3.
module tarte_exec (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic START_I,
  input wire logic [1:0] OP_I,
  input wire logic [5:0] PAGE_I,
  input wire logic [12:0] PC_I,
  input wire logic [2:0] D_REG_I,
  input wire logic [7:0] PRESCALER_I,
  input wire logic [7:0] SERIAL_I,
  input wire logic [9:0] ROM_DATA_I,
  input wire logic CARRY_I,
  output logic BUSY_O,
  output logic DONE_O,
  output logic [3:0] ACC_O,
  output logic [3:0] B_REG_O,
  output logic [2:0] STACK_POINTER_O,
  output logic [12:0] ROM_ADDR_O,
  output logic [12:0] PC_O,
  output logic CARRY_O,
  output logic SKIP_O
);
  tarte_pkg::tarte_state_type state_ff;
  tarte_pkg::tarte_state_type nxt_state;
  logic [3:0] acc_ff;
  logic [3:0] b_ff;
  logic [2:0] sp_ff;
  logic [12:0] pc_ff;
  logic [12:0] addr_ff;
  logic [12:0] return_stack_ff [0:7];
  logic done_ff;
  logic [3:0] ps_hi;
  logic [3:0] ps_lo;
  logic [3:0] si_hi;
  logic [3:0] si_lo;
  logic [3:0] rom_hi;
  logic [3:0] rom_lo;
  logic [2:0] sp_up;
  logic [12:0] table_addr;
  logic [3:0] nxt_acc;
  logic [3:0] nxt_b;
  logic [2:0] nxt_sp;
  logic [12:0] nxt_pc;

  tarte_split u_presc (.byte_i(PRESCALER_I), .hi_o(ps_hi), .lo_o(ps_lo));
  tarte_split u_sio (.byte_i(SERIAL_I), .hi_o(si_hi), .lo_o(si_lo));
  tarte_split u_rom (.byte_i(ROM_DATA_I[7:0]), .hi_o(rom_hi), .lo_o(rom_lo));

  assign sp_up = sp_ff + 3'h1;
  // Full 6-bit page operand is used, so every page 0 to 63 is reachable
  assign table_addr = {PAGE_I, D_REG_I, acc_ff};

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      tarte_pkg::TARTE_IDLE: begin
        if (START_I && OP_I == tarte_pkg::TARTE_OP_ROM) begin
          nxt_state = tarte_pkg::TARTE_CALL;
        end
      end
      tarte_pkg::TARTE_CALL: nxt_state = tarte_pkg::TARTE_FETCH;
      tarte_pkg::TARTE_FETCH: nxt_state = tarte_pkg::TARTE_RET;
      tarte_pkg::TARTE_RET: nxt_state = tarte_pkg::TARTE_IDLE;
      default: nxt_state = tarte_pkg::TARTE_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_ff <= tarte_pkg::TARTE_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // No overflow guard: a full stack wraps and overwrites the oldest entry
  always_comb begin
    nxt_sp = sp_ff;
    case (state_ff)
      tarte_pkg::TARTE_CALL: begin
        nxt_sp = sp_up;
      end
      tarte_pkg::TARTE_RET: begin
        nxt_sp = sp_ff - 3'h1;
      end
      default: begin
        nxt_sp = sp_ff;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sp_ff <= tarte_pkg::TARTE_SP_RST;
    end else begin
      sp_ff <= nxt_sp;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < (1 << tarte_pkg::TARTE_SP_W); gi++) begin : g_stack
      always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
          return_stack_ff[gi] <= tarte_pkg::TARTE_PC_RST;
        end else if (state_ff == tarte_pkg::TARTE_CALL && sp_up == 3'(gi)) begin
          return_stack_ff[gi] <= PC_I;
        end
      end
    end
  endgenerate

  // Idle tracking keeps PC_O equal to the core count between table reads
  always_comb begin
    nxt_pc = pc_ff;
    case (state_ff)
      tarte_pkg::TARTE_IDLE: begin
        nxt_pc = PC_I;
      end
      tarte_pkg::TARTE_CALL: begin
        nxt_pc = table_addr;
      end
      tarte_pkg::TARTE_RET: begin
        nxt_pc = return_stack_ff[sp_ff];
      end
      default: begin
        nxt_pc = pc_ff;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pc_ff <= tarte_pkg::TARTE_PC_RST;
    end else begin
      pc_ff <= nxt_pc;
    end
  end

  // Address is held through FETCH so the ROM word is stable when loaded
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      addr_ff <= tarte_pkg::TARTE_PC_RST;
    end else if (state_ff == tarte_pkg::TARTE_CALL) begin
      addr_ff <= table_addr;
    end
  end

  always_comb begin
    nxt_acc = acc_ff;
    nxt_b = b_ff;
    case (state_ff)
      tarte_pkg::TARTE_FETCH: begin
        nxt_b = rom_hi;
        nxt_acc = rom_lo;
      end
      tarte_pkg::TARTE_IDLE: begin
        if (START_I) begin
          case (OP_I)
            tarte_pkg::TARTE_OP_PRESC: begin
              nxt_b = ps_hi;
              nxt_acc = ps_lo;
            end
            tarte_pkg::TARTE_OP_SIO: begin
              nxt_b = si_hi;
              nxt_acc = si_lo;
            end
            tarte_pkg::TARTE_OP_DREG: begin
              // B is left alone on purpose
              nxt_acc = {tarte_pkg::TARTE_ACC_TOP_CLEAR, D_REG_I};
            end
            default: begin
              nxt_acc = acc_ff;
            end
          endcase
        end
      end
      default: begin
        nxt_acc = acc_ff;
        nxt_b = b_ff;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      acc_ff <= tarte_pkg::TARTE_ACC_RST;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      b_ff <= tarte_pkg::TARTE_B_RST;
    end else begin
      b_ff <= nxt_b;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= (state_ff == tarte_pkg::TARTE_RET) ||
                 (state_ff == tarte_pkg::TARTE_IDLE && START_I &&
                  OP_I != tarte_pkg::TARTE_OP_ROM);
    end
  end

  assign BUSY_O = state_ff != tarte_pkg::TARTE_IDLE;
  assign DONE_O = done_ff;
  assign ACC_O = acc_ff;
  assign B_REG_O = b_ff;
  assign STACK_POINTER_O = sp_ff;
  assign ROM_ADDR_O = addr_ff;
  assign PC_O = pc_ff;
  assign CARRY_O = CARRY_I;
  assign SKIP_O = 1'b0;
endmodule : tarte_exec

// ==== test/tarte_rom_model.sv ====
`timescale 1ns/1ps
module tarte_rom_model (
  input logic [12:0] addr_i,
  output logic [9:0] data_o
);
  // Top bits set so a core that used them would show it
  assign data_o = {2'h3, addr_i[7:0] ^ 8'h5A};
endmodule : tarte_rom_model

// ==== test/tarte_exec_monitor.sv ====
`timescale 1ns/1ps
module tarte_monitor (
  input logic REF_CLK_I, RST_N_I, START_I, CARRY_I, BUSY_O, DONE_O, CARRY_O, SKIP_O,
  input logic [1:0] OP_I,
  input logic [2:0] D_REG_I, STACK_POINTER_O,
  input logic [3:0] ACC_O, B_REG_O,
  input logic [5:0] PAGE_I,
  input logic [7:0] PRESCALER_I, SERIAL_I,
  input logic [9:0] ROM_DATA_I,
  input logic [12:0] PC_I, PC_O, ROM_ADDR_O
);
  logic [7:0] rom_q_ff;
  logic take;
  assign take = START_I && !BUSY_O;
  always_ff @(posedge REF_CLK_I) rom_q_ff <= ROM_DATA_I[7:0];
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  rom_call_a: assert property (
    take && OP_I == 2'h0 |-> ##2 STACK_POINTER_O == $past(STACK_POINTER_O, 2) + 3'h1
    && ROM_ADDR_O == {$past(PAGE_I, 2), $past(D_REG_I, 2), $past(ACC_O, 2)})
    else $error("bad table call");
  rom_load_a: assert property (
    take && OP_I == 2'h0 |-> ##3 {B_REG_O, ACC_O} == rom_q_ff) else $error("bad table load");
  rom_return_a: assert property (
    take && OP_I == 2'h0 |=> BUSY_O [*3] ##1 (DONE_O && !BUSY_O
    && STACK_POINTER_O == $past(STACK_POINTER_O, 4) && PC_O == $past(PC_I, 4)))
    else $error("bad table return");
  top_page_a: assert property (
    take && OP_I == 2'h0 && PAGE_I == 6'h3F |-> ##2 PC_O[12:7] == 6'h3F) else $error("bad page");
  presc_copy_a: assert property (
    take && OP_I == 2'h1 |=> DONE_O && {B_REG_O, ACC_O} == $past(PRESCALER_I))
    else $error("bad prescaler copy");
  serial_copy_a: assert property (
    take && OP_I == 2'h2 |=> {B_REG_O, ACC_O} == $past(SERIAL_I)) else $error("bad serial copy");
  dreg_low_a: assert property (
    take && OP_I == 2'h3 |=> ACC_O[2:0] == $past(D_REG_I) && B_REG_O == $past(B_REG_O))
    else $error("bad d copy");
  dreg_top_a: assert property (
    take && OP_I == 2'h3 |=> !ACC_O[3]) else $error("acc top bit set");
  flags_kept_a: assert property (
    CARRY_O == CARRY_I && !SKIP_O) else $error("carry or skip disturbed");
endmodule : tarte_monitor
bind tarte_exec tarte_monitor u_mon (.*);

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic REF_CLK_I, RST_N_I, START_I, CARRY_I, BUSY_O, DONE_O, CARRY_O, SKIP_O;
  logic [1:0] OP_I;
  logic [2:0] D_REG_I, STACK_POINTER_O;
  logic [3:0] ACC_O, B_REG_O;
  logic [5:0] PAGE_I;
  logic [7:0] PRESCALER_I, SERIAL_I;
  logic [9:0] ROM_DATA_I;
  logic [12:0] PC_I, PC_O, ROM_ADDR_O;
  int num_errors = 0;
  int check_count = 0;
  tarte_exec u_dut (
    .REF_CLK_I(REF_CLK_I),
    .RST_N_I(RST_N_I),
    .START_I(START_I),
    .OP_I(OP_I),
    .PAGE_I(PAGE_I),
    .PC_I(PC_I),
    .D_REG_I(D_REG_I),
    .PRESCALER_I(PRESCALER_I),
    .SERIAL_I(SERIAL_I),
    .ROM_DATA_I(ROM_DATA_I),
    .CARRY_I(CARRY_I),
    .BUSY_O(BUSY_O),
    .DONE_O(DONE_O),
    .ACC_O(ACC_O),
    .B_REG_O(B_REG_O),
    .STACK_POINTER_O(STACK_POINTER_O),
    .ROM_ADDR_O(ROM_ADDR_O),
    .PC_O(PC_O),
    .CARRY_O(CARRY_O),
    .SKIP_O(SKIP_O)
  );
  tarte_rom_model u_rom (.addr_i(ROM_ADDR_O), .data_o(ROM_DATA_I));
  initial begin
    REF_CLK_I = 1'b0;
    forever #5 REF_CLK_I = ~REF_CLK_I;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic issue(input logic [1:0] op);
    @(posedge REF_CLK_I);
    #1 OP_I = op;
    START_I = 1'b1;
    @(posedge REF_CLK_I);
    #1 START_I = 1'b0;
  endtask : issue
  task automatic t_xfer;
    issue(2'h1);
    check({B_REG_O, ACC_O, 7'h0, DONE_O}, 16'hC301);
    issue(2'h2);
    check({B_REG_O, ACC_O}, 8'h9E);
    issue(2'h3);
    check({B_REG_O, ACC_O}, 8'h95);
    check({CARRY_O, SKIP_O}, 2'h2);
    CARRY_I = 1'b0;
    #1 check({CARRY_O, SKIP_O}, 2'h0);
    CARRY_I = 1'b1;
    $display("t_xfer done");
  endtask : t_xfer
  // Stack is empty here, so the temporary push has a free level
  task automatic t_rom(input logic [5:0] page);
    logic [12:0] adr;
    adr = {page, D_REG_I, ACC_O};
    PAGE_I = page;
    issue(2'h0);
    @(posedge REF_CLK_I);
    #1 PC_I = 13'h0F0F;
    repeat (2) @(posedge REF_CLK_I);
    #1 check({DONE_O, B_REG_O, ACC_O}, {1'b1, adr[7:0] ^ 8'h5A});
    check({STACK_POINTER_O, PC_O}, {3'h7, 13'h1ABC});
    check(ROM_ADDR_O, adr);
    @(posedge REF_CLK_I);
    #1 PC_I = 13'h1ABC;
    $display("t_rom done");
  endtask : t_rom
  task automatic t_reset;
    @(posedge REF_CLK_I);
    #1 RST_N_I = 1'b0;
    #1 check({ACC_O, B_REG_O, STACK_POINTER_O, DONE_O, BUSY_O}, 16'h001C);
    check(PC_O, 16'h0000);
    check(ROM_ADDR_O, 16'h0000);
    @(posedge REF_CLK_I);
    #1 RST_N_I = 1'b1;
    $display("t_reset done");
  endtask : t_reset
  initial begin
    RST_N_I = 1'b0;
    START_I = 1'b0;
    OP_I = 2'h0;
    PAGE_I = 6'h00;
    PC_I = 13'h1ABC;
    D_REG_I = 3'h5;
    PRESCALER_I = 8'hC3;
    SERIAL_I = 8'h9E;
    CARRY_I = 1'b1;
    repeat (16) @(posedge REF_CLK_I);
    #1 RST_N_I = 1'b1;
    t_xfer();
    t_rom(6'h3F);
    t_reset();
    t_rom(6'h00);
    give_verdict();
  end
  initial begin
    #3000;
    num_errors++;
    give_verdict();
  end
endmodule : testbench
